// ==== srwb_builder.sv ====
// srwb_builder: link slave that frames and checks sensor response words
// How it works
// - answer words are 32 bits, fixed fields
// - data monitor words use mode 101
// - global words use mode 000
// - nvm error word: addr 01000, zeros
// - bad clock count or crc: link-error word
// - unknown or illegal command: invalid-command word
// - bit 7 mirrors continuous self-test state
// - fault shows as mode bits 01
// - bit 6 flags accelerometer channel fault
// - bits 5:4 keep-alive count per data word
// - first answer after reset is config status
// - nvm write commands repeat word N-1
// - link-error and invalid-command words held until a listed status request
// - crc x^4+1, seed 1010, msb first
// - check incoming crc, drop bad commands
// - rate is signed 16 bit
// - acceleration is signed 16 bit
// - temperature is unsigned 16 bit
// - self-test flags in bits 31:17
// - version word layout
// - inverted version word layout
// - identity and revision come from nvm
// - answer comes in the following exchange
// - self-test adds offset and reports fault
//
// Local design decisions: the register offsets and the Wishbone register port.
module srwb_builder
  import srwb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial link pins, host is master
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  // measurements and status from the sensor core, same clock
  input wire logic [15:0] rate_i,
  input wire logic [15:0] acc_y_i,
  input wire logic [15:0] acc_x_i,
  input wire logic [15:0] temp_i,
  input wire logic [15:0] config_i,
  input wire logic [14:0] test_flags_i,
  input wire logic fault_i,
  input wire logic acc_fault_i,
  // nvm read port and identity held in nvm
  output logic [4:0] nvm_addr_o,
  input wire logic [15:0] nvm_data_i,
  input wire logic nvm_err_i,
  input wire logic [2:0] nvm_dev_id_i,
  input wire logic [4:0] nvm_rev_i
);

  // crc over the 28 upper bits, one bit per step
  function automatic logic [3:0] crc4(input logic [27:0] bits);
    logic [3:0] c;
    c = CRC_SEED;
    for (int i = 27; i >= 0; i--) begin
      c = {c[2:0], c[3] ^ bits[i]};
    end
    return c;
  endfunction

  // a request that names a listed answer type
  function automatic logic is_status_req(input logic [2:0] m,
                                         input logic [4:0] a);
    logic ok;
    ok = 1'b0;
    if (m == MODE_DATA) begin
      ok = (a <= ADR_TEMP);
    end else if (m == MODE_GLOBAL) begin
      ok = (a == CMD_CFG_REQ) || (a == CMD_BIT) || (a == CMD_NVM_RD) ||
           (a == CMD_VER) || (a == CMD_INV_VER);
    end
    return ok;
  endfunction

  // two-flop synchronisers for the pins
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic sclk_prev_q; // last synchronised clock level
  logic cs_prev_q; // last synchronised select level

  // link shift state
  logic [31:0] rx_q; // incoming command shift
  logic [5:0] edge_cnt_q; // rising clock edges this frame
  logic [31:0] tx_q; // outgoing shift
  srwb_word_t cur_q; // word sent in this exchange
  srwb_word_t prev_q; // word sent in the exchange before
  srwb_word_t next_d; // word for the following exchange
  logic data_word; // next_d is a fresh data monitor word

  // protocol state
  logic first_q; // no frame finished since reset
  logic hold_q; // an error word is being held
  logic continuous_self_test_flag_q; // continuous self-test on
  logic [1:0] keep_alive_counter_q; // keep-alive count
  logic [31:0] ctrl_q; // software control register
  logic [31:0] last_rx_q; // last command accepted
  logic ack_q; // bus answer

  // decoded pin events
  logic sclk_s, cs_n_s, mosi_s;
  logic sclk_rise, sclk_fall, frame_start, frame_end;
  assign sclk_s = sync2_q[0];
  assign cs_n_s = sync2_q[1];
  assign mosi_s = sync2_q[2];
  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
  assign frame_start = cs_prev_q & ~cs_n_s;
  assign frame_end = ~cs_prev_q & cs_n_s;

  // pins pass two flops before any logic looks at them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // idle levels: select high, clock low, so no false edge after reset
      sync1_q <= 3'h2;
      sync2_q <= 3'h2;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sync1_q <= {spi_mosi_i, spi_cs_n_i, spi_sclk_i};
      sync2_q <= sync1_q;
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
    end
  end

  // receive: sample on rising clock, count edges per frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_q <= 32'h0;
      edge_cnt_q <= 6'h0;
    end else if (frame_start) begin
      edge_cnt_q <= 6'h0;
    end else if (sclk_rise) begin
      rx_q <= {rx_q[30:0], mosi_s};
      // saturate so a long frame never wraps back to 32
      if (edge_cnt_q != 6'h3f) begin
        edge_cnt_q <= edge_cnt_q + 6'h1;
      end
    end
  end

  // command checks on the frame just ended
  logic [2:0] rx_mode;
  logic [4:0] rx_addr, rx_nvm;
  logic link_bad, cmd_known, cmd_illegal, cmd_status, cmd_nvm_wr;
  assign rx_mode = rx_q[15:13];
  assign rx_addr = rx_q[12:8];
  assign rx_nvm = rx_q[20:16];
  assign link_bad = (edge_cnt_q != FRAME_BITS) ||
                    (crc4(rx_q[31:4]) != rx_q[3:0]);
  assign cmd_status = is_status_req(rx_mode, rx_addr);
  assign cmd_nvm_wr = (rx_mode == MODE_GLOBAL) &&
                      ((rx_addr == CMD_NVM_WD) || (rx_addr == CMD_NVM_WR) ||
                       (rx_addr == CMD_NVM_ER));
  assign cmd_known = cmd_status || cmd_nvm_wr ||
                     ((rx_mode == MODE_GLOBAL) && (rx_addr == CMD_CFG_SET));
  // reads past the serial numbers and writes past user space are refused
  assign cmd_illegal = (rx_mode == MODE_GLOBAL) &&
      (((rx_addr == CMD_NVM_RD) && (rx_nvm > NVM_READ_LAST)) ||
       (((rx_addr == CMD_NVM_WR) || (rx_addr == CMD_NVM_ER)) &&
        (rx_nvm > NVM_USER_LAST)));
  logic cmd_bad;
  assign cmd_bad = ~link_bad & (~cmd_known | cmd_illegal);
  assign nvm_addr_o = rx_nvm; // nvm answers within the same cycle

  // fault and self-test adjustments
  logic fault;
  logic [15:0] st_off;
  assign fault = fault_i | continuous_self_test_flag_q;
  assign st_off = continuous_self_test_flag_q ? ctrl_q[15:0] : 16'h0;

  // next answer word, built as the frame ends
  always_comb begin
    next_d = '0;
    data_word = 1'b0;
    next_d.continuous_self_test_flag = continuous_self_test_flag_q;
    next_d.mode = MODE_GLOBAL;
    if (link_bad) begin
      next_d.addr = RSP_LINK_ERR;
    end else if (hold_q && !cmd_status) begin
      next_d = cur_q;
    end else if (first_q) begin
      next_d.addr = RSP_CFG;
      next_d.data = config_i;
    end else if (cmd_bad) begin
      next_d.addr = RSP_BAD_CMD;
    end else if (cmd_nvm_wr) begin
      next_d = prev_q;
    end else if (rx_mode == MODE_DATA) begin
      next_d.mode = MODE_DATA;
      data_word = 1'b1;
      next_d.ka = keep_alive_counter_q;
      case (rx_addr)
        ADR_RATE: next_d.data = rate_i + st_off;
        ADR_ACCY: begin
          next_d.data = acc_y_i + st_off;
          next_d.acc = acc_fault_i;
        end
        ADR_ACCX: begin
          next_d.data = acc_x_i + st_off;
          next_d.acc = acc_fault_i;
        end
        default: next_d.data = temp_i;
      endcase
      next_d.addr = rx_addr;
    end else begin
      case (rx_addr)
        CMD_BIT: begin
          next_d.addr = RSP_BIT;
          next_d.data = {test_flags_i, 1'b0};
        end
        CMD_NVM_RD: begin
          if (nvm_err_i) begin
            next_d.addr = RSP_NVM_ERR;
            next_d.continuous_self_test_flag = 1'b0;
          end else begin
            next_d.addr = RSP_NVM;
            next_d.data = nvm_data_i;
          end
        end
        CMD_VER: begin
          next_d.addr = RSP_VER;
          next_d.data = {VER_TOP, nvm_dev_id_i, 1'b1, nvm_rev_i};
          {next_d.continuous_self_test_flag, next_d.acc, next_d.ka} = VER_LOW[3:0];
        end
        CMD_INV_VER: begin
          next_d.addr = RSP_INV_VER;
          next_d.data = {~VER_TOP, ~nvm_dev_id_i, 1'b0, ~nvm_rev_i};
          {next_d.continuous_self_test_flag, next_d.acc, next_d.ka} = INV_LOW[3:0];
        end
        default: begin
          next_d.addr = RSP_CFG;
          next_d.data = config_i;
        end
      endcase
    end
    // fault pattern on ordinary words; fixed-format words keep their mode
    if (fault && next_d.addr != RSP_NVM_ERR && !(next_d.mode == MODE_GLOBAL &&
        (next_d.addr == RSP_VER || next_d.addr == RSP_INV_VER))) begin
      next_d.mode[2:1] = MODE_FAULT;
    end
    next_d.crc = crc4({next_d.data, next_d.mode, next_d.addr, next_d.continuous_self_test_flag,
                       next_d.acc, next_d.ka});
  end

  // answer pipeline: built at frame end, sent in the following frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_q <= '0;
      prev_q <= '0;
      first_q <= 1'b1;
    end else if (frame_end) begin
      prev_q <= cur_q;
      cur_q <= next_d;
      first_q <= 1'b0;
    end
  end

  // error hold: set by a link-error or invalid-command word, cleared by a listed request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= 1'b0;
    end else if (frame_end) begin
      hold_q <= (next_d.mode[0] == MODE_GLOBAL[0]) &&
                (next_d.addr == RSP_LINK_ERR ||
                 next_d.addr == RSP_BAD_CMD);
    end
  end

  // self-test flag follows bit 7 of each good command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      continuous_self_test_flag_q <= 1'b0;
      last_rx_q <= 32'h0;
    end else if (frame_end && !link_bad) begin
      continuous_self_test_flag_q <= rx_q[7];
      last_rx_q <= rx_q;
    end
  end

  // keep-alive count steps once per data monitor word; the fault pattern
  // rewrites the mode bits, so the mode field cannot be used to spot one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keep_alive_counter_q <= 2'h0;
    end else if (frame_end && data_word) begin
      keep_alive_counter_q <= keep_alive_counter_q + 2'h1;
    end
  end

  // transmit: load at frame start, shift on falling clock edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_q <= 32'h0;
    end else if (frame_start) begin
      tx_q <= cur_q;
    end else if (sclk_fall) begin
      tx_q <= {tx_q[30:0], 1'b0};
    end
  end
  assign spi_miso_o = tx_q[31];
  assign spi_miso_oe_o = ~cs_n_s;

  // wishbone: one wait state, answer for every address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end
  assign wb_ack_o = ack_q;

  // control register write, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (ack_q && wb_we_i && wb_adr_i == REG_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          ctrl_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  // read mux registered; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else begin
      case (wb_adr_i)
        REG_CTRL: wb_dat_o <= ctrl_q;
        REG_STATUS: wb_dat_o <= {27'h0, keep_alive_counter_q, continuous_self_test_flag_q, hold_q, first_q};
        REG_LAST_TX: wb_dat_o <= cur_q;
        REG_LAST_RX: wb_dat_o <= last_rx_q;
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // checks
  answer_crc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end |=> cur_q.crc == crc4(cur_q[31:4]))
    else $error("answer crc wrong");
  link_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end && link_bad |=> cur_q.addr == RSP_LINK_ERR &&
    cur_q.data == 16'h0)
    else $error("link error word missing");
  first_cfg_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end && first_q && !link_bad |=> cur_q.addr == RSP_CFG)
    else $error("first answer not config status");
  nvm_repeat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end && !link_bad && !hold_q && !first_q && cmd_nvm_wr &&
    !cmd_illegal |=> cur_q[31:4] == $past(prev_q[31:4]))
    else $error("nvm write did not repeat old word");
  hold_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end && hold_q && !link_bad && !cmd_status
    |=> $stable(cur_q))
    else $error("held error word dropped");
  keep_alive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end && cur_q.mode[2] && cur_q.mode[0] && data_word
    |=> cur_q.ka == $past(cur_q.ka) + 2'h1)
    else $error("keep alive did not step");
  continuous_self_test_flag_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end && !link_bad && !hold_q && !first_q &&
    rx_mode == MODE_DATA |=> cur_q.continuous_self_test_flag == $past(continuous_self_test_flag_q, 1)
    && (cur_q.mode[2:1] == MODE_FAULT) == $past(fault_i | continuous_self_test_flag_q, 1))
    else $error("self-test bit or fault mode wrong");
  tx_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_start |=> spi_miso_o == cur_q[31] && spi_miso_oe_o)
    else $error("answer not loaded at frame start");
  bit_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_end ##1 cur_q.addr == RSP_BIT && cur_q.mode[0] == 1'b0
    |-> cur_q.data[0] == 1'b0)
    else $error("spare self-test bit set");

endmodule // srwb_builder

// ==== srwb_builder_bench.sv ====
// srwb_builder_bench: self-checking bench for the response word builder
module srwb_builder_bench import srwb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] MD = MODE_DATA;
  localparam logic [2:0] MG = MODE_GLOBAL;
  localparam logic [15:0] RATE_V = 16'h8123; // negative rate
  localparam logic [15:0] ACCY_V = 16'h7ffe;
  localparam logic [15:0] ACCX_V = 16'h0001;
  localparam logic [15:0] TEMP_V = 16'h0960;
  localparam logic [15:0] CFG_V = 16'h0a5c;
  localparam logic [14:0] FLAGS_V = 15'h4a53;
  localparam logic [2:0] DEV_V = 3'h5; // arbitrary identity
  localparam logic [4:0] REV_V = 5'h13; // arbitrary revision
  localparam logic [31:0] VW = {VER_TOP, DEV_V, 1'b1, REV_V, VER_LOW, 4'h0};
  localparam logic [31:0] IW = {7'h00, ~DEV_V, 1'b0, ~REV_V, INV_LOW, 4'h0};
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic sclk, cs_n, mosi, miso, miso_oe;
  logic [15:0] rate_i, acc_y_i, acc_x_i, temp_i, config_i, nvm_data_i;
  logic [14:0] test_flags_i;
  logic fault_i, acc_fault_i, nvm_err_i, continuous_self_test_flag_tx, ka_set;
  logic [4:0] nvm_addr_o;
  logic [1:0] ka; // keep-alive value last seen
  int num_errors = 0;
  int checks_done = 0;

  srwb_builder i_srwb_builder (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(miso_oe), .rate_i(rate_i), .acc_y_i(acc_y_i),
    .acc_x_i(acc_x_i), .temp_i(temp_i), .config_i(config_i),
    .test_flags_i(test_flags_i), .fault_i(fault_i),
    .acc_fault_i(acc_fault_i), .nvm_addr_o(nvm_addr_o),
    .nvm_data_i(nvm_data_i), .nvm_err_i(nvm_err_i),
    .nvm_dev_id_i(DEV_V), .nvm_rev_i(REV_V));
  srwb_host_model i_srwb_host_model (.sclk_o(sclk), .cs_n_o(cs_n),
    .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));

  // nvm stand-in: content echoes the location in its low bits
  assign nvm_data_i = {11'h2b6, nvm_addr_o};

  // 10 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  function automatic logic [3:0] crc4(input logic [27:0] d);
    logic [3:0] c;
    c = CRC_SEED;
    for (int i = 27; i >= 0; i--) begin
      c = {c[2:0], c[3] ^ d[i]};
    end
    return c;
  endfunction

  // command word, self-test request taken from continuous_self_test_flag_tx
  function automatic logic [31:0] cw(input logic [4:0] a,
      input logic [2:0] m, input logic [15:0] d, input logic [2:0] lo);
    logic [27:0] b;
    b = {d, m, a, continuous_self_test_flag_tx, lo};
    return {b, crc4(b)};
  endfunction

  // expected data word; fc is {fault, self-test}
  function automatic logic [31:0] dw(input logic [15:0] d,
      input logic [4:0] a, input logic b6, input logic [1:0] fc);
    return {d, fc[1] ? 3'b011 : MD, a, fc[0], b6, 6'h00};
  endfunction

  // expected global word
  function automatic logic [31:0] gw(input logic [15:0] d,
      input logic [4:0] a, input logic [1:0] fc);
    return {d, fc[1] ? 3'b010 : MG, a, fc[0], 7'h00};
  endfunction

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] got);
    checks_done++;
    if (got !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask

  // one exchange; rx carries the answer to the previous request
  task automatic ex(input logic [31:0] tx, input int n,
                    input logic [31:0] e);
    logic [31:0] rx;
    i_srwb_host_model.xfer(tx, n, rx);
    if (e[13] === 1'b1) begin
      e[5:4] = ka_set ? ka + 2'd1 : rx[5:4]; // first one sets the phase
      ka = e[5:4];
      ka_set = 1'b1;
    end
    e[3:0] = crc4(e[31:4]);
    check("response word", e >> (32 - n), rx);
  endtask

  // classic wishbone single cycle, waits for ack under a bound
  task automatic wb_xfer(input logic we, input logic [7:0] a,
                         input logic [31:0] wd, output logic [31:0] rd);
    logic got;
    got = 1'b0;
    rd = '0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge clk_i);
      got = (wb_ack_o === 1'b1);
    end
    rd = wb_dat_o;
    if (!got) begin
      check("bus ack", 32'h1, 32'h0);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard, about four times the expected run
  initial begin
    #3000000;
    num_errors++;
    conclude();
  end

  // main sequence
  initial begin
    logic [31:0] rd;
    logic [31:0] e;
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'b1000;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    {rate_i, acc_y_i, acc_x_i} = {RATE_V, ACCY_V, ACCX_V};
    {temp_i, config_i, test_flags_i} = {TEMP_V, CFG_V, FLAGS_V};
    {fault_i, acc_fault_i, nvm_err_i, continuous_self_test_flag_tx, ka_set} = 5'b00000;
    ka = 2'b00;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb_xfer(1'b0, REG_CTRL, 32'h0, rd);
    check("ctrl reset", CTRL_RESET, rd);
    wb_xfer(1'b1, REG_CTRL, 32'h0000_0010, rd);
    wb_xfer(1'b0, REG_CTRL, 32'h0, rd);
    check("ctrl offset", 32'h0000_0010, rd);
    wb_xfer(1'b0, 8'h40, 32'h0, rd);
    check("unmapped read", 32'h0, rd);
    acc_fault_i <= 1'b1;
    i_srwb_host_model.xfer(cw(ADR_RATE, MD, 16'h0, 3'h0), 32, rd);
    ex(cw(ADR_ACCY, MD, 16'h0, 3'h0), 32, gw(CFG_V, RSP_CFG, 0));
    ex(cw(ADR_ACCX, MD, 0, 0), 32, dw(ACCY_V, ADR_ACCY, 1, 0));
    ex(cw(ADR_TEMP, MD, 0, 0), 32, dw(ACCX_V, ADR_ACCX, 1, 0));
    fault_i <= 1'b1;
    ex(cw(ADR_RATE, MD, 0, 0), 32, dw(TEMP_V, ADR_TEMP, 0, 0));
    ex(cw(CMD_CFG_REQ, MG, 0, 0), 32, dw(RATE_V, ADR_RATE, 0, 2));
    fault_i <= 1'b0;
    ex(cw(CMD_BIT, MG, 0, 0), 32, gw(CFG_V, RSP_CFG, 2));
    ex(cw(CMD_NVM_RD, MG, 16'h0d, 0), 32, gw({FLAGS_V, 1'b0}, RSP_BIT, 0));
    ex(cw(CMD_VER, MG, 16'hffff, 6), 32,
       gw({11'h2b6, 5'h0d}, RSP_NVM, 0));
    ex(cw(CMD_INV_VER, MG, 0, 1), 32, VW);
    ex(cw(CMD_NVM_WD, MG, 16'h1234, 0), 32, IW);
    ex(cw(ADR_RATE, MD, 0, 0), 32, VW);
    ex(cw(CMD_NVM_RD, MG, 16'h11, 0), 32, dw(RATE_V, ADR_RATE, 0, 0));
    ex(cw(CMD_CFG_SET, MG, 0, 0), 32, gw(0, RSP_BAD_CMD, 0));
    ex(cw(ADR_TEMP, MD, 0, 0), 32, gw(0, RSP_BAD_CMD, 0));
    ex(cw(ADR_ACCY, MD, 0, 0) ^ 1, 32, dw(TEMP_V, ADR_TEMP, 0, 0));
    ex(cw(CMD_CFG_REQ, MG, 0, 0), 32, gw(0, RSP_LINK_ERR, 0));
    ex(cw(CMD_CFG_REQ, MG, 0, 0), 31, gw(CFG_V, RSP_CFG, 0));
    ex(cw(ADR_TEMP, MD, 0, 0), 32, gw(0, RSP_LINK_ERR, 0));
    ex(cw(ADR_RATE, MD, 0, 0), 32, dw(TEMP_V, ADR_TEMP, 0, 0));
    nvm_err_i <= 1'b1;
    ex(cw(CMD_NVM_RD, MG, 16'h03, 0), 32, dw(RATE_V, ADR_RATE, 0, 0));
    nvm_err_i <= 1'b0;
    ex(cw(ADR_RATE, MD, 0, 0), 32, gw(0, RSP_NVM_ERR, 0));
    continuous_self_test_flag_tx = 1'b1;
    ex(cw(CMD_VER, MG, 16'hffff, 6), 32, dw(RATE_V, ADR_RATE, 0, 0));
    ex(cw(ADR_RATE, MD, 0, 0), 32, VW);
    continuous_self_test_flag_tx = 1'b0;
    ex(cw(CMD_INV_VER, MG, 0, 1), 32, dw(RATE_V + 16'h10, 0, 0, 3));
    ex(cw(ADR_RATE, MD, 0, 0), 32, IW);
    ex(cw(ADR_RATE, MD, 0, 0), 32, dw(RATE_V, ADR_RATE, 0, 0));
    // last word built is one more rate word, one count further on
    e = dw(RATE_V, ADR_RATE, 0, 0);
    e[5:4] = ka + 2'd1;
    e[3:0] = crc4(e[31:4]);
    wb_xfer(1'b0, REG_LAST_TX, 32'h0, rd);
    check("last sent word", e, rd);
    wb_xfer(1'b0, REG_STATUS, 32'h0, rd);
    check("status", {27'h0, ka + 2'd2, 3'b000}, rd);
    conclude();
  end
endmodule // srwb_builder_bench

// ==== srwb_host_model.sv ====
// srwb_host_model: behavioural link master standing in for the host
module srwb_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF_NS = 400; // half of the 800 ns link clock

  // idle: clock low, not selected
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // one exchange of n rising edges, msb first, mode 0
  task automatic xfer(input logic [31:0] tx, input int n,
                      output logic [31:0] rx);
    rx = '0;
    #37; // keeps link edges away from system clock edges
    cs_n_o = 1'b0;
    #600; // answer needs a few clocks to load after select
    for (int i = 0; i < n; i++) begin
      mosi_o = tx[31-i];
      #HALF_NS;
      sclk_o = 1'b1;
      // undriven miso reads low, never as the last bit
      rx = {rx[30:0], miso_oe_i ? miso_i : 1'b0};
      #HALF_NS;
      sclk_o = 1'b0;
    end
    #HALF_NS;
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // stale level must not look like data
    #1200; // select gap between exchanges
  endtask
endmodule // srwb_host_model

// ==== srwb_pkg.sv ====
// srwb_pkg: constants and word layout for the sensor response word builder
package srwb_pkg;
  // response word layout, msb first
  typedef struct packed {
    logic [15:0] data; // payload
    logic [2:0] mode; // message class
    logic [4:0] addr; // message address
    logic continuous_self_test_flag; // continuous self-test active
    logic acc; // accelerometer channel fault
    logic [1:0] ka; // keep-alive count or fixed bits
    logic [3:0] crc; // check nibble
  } srwb_word_t;
  // mode codes
  localparam logic [2:0] MODE_DATA = 3'h5;
  localparam logic [2:0] MODE_GLOBAL = 3'h0;
  localparam logic [1:0] MODE_FAULT = 2'h1; // pattern in mode bits 2:1
  // data monitor addresses (same in command and answer)
  localparam logic [4:0] ADR_RATE = 5'h00;
  localparam logic [4:0] ADR_ACCY = 5'h01;
  localparam logic [4:0] ADR_ACCX = 5'h02;
  localparam logic [4:0] ADR_TEMP = 5'h03;
  // global command addresses
  localparam logic [4:0] CMD_CFG_REQ = 5'h00;
  localparam logic [4:0] CMD_INV_VER = 5'h01;
  localparam logic [4:0] CMD_CFG_SET = 5'h02;
  localparam logic [4:0] CMD_BIT = 5'h03;
  localparam logic [4:0] CMD_NVM_RD = 5'h04;
  localparam logic [4:0] CMD_NVM_WD = 5'h05;
  localparam logic [4:0] CMD_NVM_WR = 5'h06;
  localparam logic [4:0] CMD_NVM_ER = 5'h07;
  localparam logic [4:0] CMD_VER = 5'h10;
  // global answer addresses
  localparam logic [4:0] RSP_CFG = 5'h00;
  localparam logic [4:0] RSP_INV_VER = 5'h01;
  localparam logic [4:0] RSP_BIT = 5'h02;
  localparam logic [4:0] RSP_NVM = 5'h03;
  localparam logic [4:0] RSP_NVM_ERR = 5'h08;
  localparam logic [4:0] RSP_LINK_ERR = 5'h09;
  localparam logic [4:0] RSP_BAD_CMD = 5'h0a;
  localparam logic [4:0] RSP_VER = 5'h10;
  // version word fixed fields
  localparam logic [6:0] VER_TOP = 7'h7f;
  localparam logic [11:0] VER_LOW = 12'h10e;
  localparam logic [11:0] INV_LOW = 12'h011;
  // nvm access limits
  localparam logic [4:0] NVM_USER_LAST = 5'h0c;
  localparam logic [4:0] NVM_READ_LAST = 5'h10;
  // link framing and check
  localparam logic [3:0] CRC_SEED = 4'ha;
  localparam logic [5:0] FRAME_BITS = 6'd32;
  // wishbone register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LAST_TX = 8'h08;
  localparam logic [7:0] REG_LAST_RX = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage
